/* include/fcs_pkg.sv */
package fcs_pkg;
	// instruction word field positions
	localparam int MAJOR_LSB = 26;
	localparam int RA_LSB    = 16;
	localparam int RB_LSB    = 11;
	localparam logic [5:0] MAJOR_FLOAT = 6'h32;
	// minor opcodes
	localparam logic [7:0] MIN_GT_S  = 8'h0A;
	localparam logic [7:0] MIN_LE_S  = 8'h0D;
	localparam logic [7:0] MIN_LT_S  = 8'h0C;
	localparam logic [7:0] MIN_NE_S  = 8'h09;
	localparam logic [7:0] MIN_GT_D  = 8'h1A;
	localparam logic [7:0] MIN_LE_D  = 8'h1D;
	localparam logic [7:0] MIN_LT_D  = 8'h1C;
	localparam logic [7:0] MIN_NE_D  = 8'h19;
	localparam logic [7:0] MIN_UEQ_D = 8'h38;
	// reset values of the flag and sticky bits
	localparam logic FLAG_RST = 1'b0;
	localparam logic STICKY_RST = 1'b0;
	// comparison relation selected by the minor code
	typedef enum logic [2:0] {
		FCS_GT, FCS_LE, FCS_LT, FCS_NE, FCS_UEQ
	} fcs_rel_t;
endpackage

/* verilog/fcs_class.sv */
`timescale 1ns/1ps
`default_nettype none
// classifies one ieee operand of either precision
module fcs_class (
	input  wire logic [63:0] opnd,
	input  wire logic        dbl,
	output logic             is_inf,
	output logic             is_nan,
	output logic             is_snan,
	output logic             is_zero
);
	logic        exp_ones; // exponent all ones
	logic        man_nz;   // mantissa nonzero
	logic        quiet;    // top mantissa bit
	logic        mag_zero; // magnitude zero (+0 and -0)
	// field extraction per precision
	always_comb begin
		if (dbl) begin
			exp_ones = &opnd[62:52];
			man_nz   = |opnd[51:0];
			quiet    = opnd[51];
			mag_zero = ~|opnd[62:0];
		end else begin
			exp_ones = &opnd[30:23];
			man_nz   = |opnd[22:0];
			quiet    = opnd[22];
			mag_zero = ~|opnd[30:0];
		end
	end
	assign is_inf  = exp_ones & ~man_nz;
	assign is_nan  = exp_ones & man_nz;
	assign is_snan = exp_ones & man_nz & ~quiet;
	assign is_zero = mag_zero;
endmodule
`default_nettype wire

/* verilog/fcs_compare.sv */
`timescale 1ns/1ps
`default_nettype none
// float set-flag compare unit; result registered one cycle after issue
module fcs_compare #(
	parameter int CORE_W = 32 // 32 pairs registers, 64 full registers
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              clk_en,
	input  wire logic              issue,
	input  wire logic [31:0]       insn,
	input  wire logic [CORE_W-1:0] opa_hi,
	input  wire logic [CORE_W-1:0] opa_lo,
	input  wire logic [CORE_W-1:0] opb_hi,
	input  wire logic [CORE_W-1:0] opb_lo,
	input  wire logic              unbounded_clr,
	input  wire logic              invalid_clr,
	output logic                   insn_hit,
	output logic                   gpr_write,
	output logic                   flag_we_q,
	output logic                   compare_flag_q,
	output logic                   operand_unbounded_bit_q,
	output logic                   invalid_op_bit_q
);
	// elaboration check on core width
	// only 32 has a path of its own; any other width goes down the
	// 64-bit path, which zero-extends or truncates the lo port to 64 bits
	if (CORE_W != 32 && CORE_W != 64) begin : g_bad_width
		$error("fcs_compare: CORE_W must be 32 or 64");
	end

	////////////////////////////////////////////////////////////////////////
	// decode
	// issue qualifies the word; the reserved fields between the operand
	// selectors and the minor code are not checked, so junk left there
	// by the issue stage does not cost a compare
	logic [5:0]      major;   // top six bits
	logic [7:0]      minor;   // bottom eight bits
	logic            dbl;     // double precision op
	logic            legal;   // recognised compare
	fcs_pkg::fcs_rel_t rel;   // selected relation

	assign major = insn[31:fcs_pkg::MAJOR_LSB];
	assign minor = insn[7:0];

	// minor opcode lookup; unknown codes are not ours
	always_comb begin
		dbl   = 1'b0;
		legal = 1'b1;
		rel   = fcs_pkg::FCS_GT;
		unique case (minor)
			fcs_pkg::MIN_GT_S: rel = fcs_pkg::FCS_GT;
			fcs_pkg::MIN_LE_S: rel = fcs_pkg::FCS_LE;
			fcs_pkg::MIN_LT_S: rel = fcs_pkg::FCS_LT;
			fcs_pkg::MIN_NE_S: rel = fcs_pkg::FCS_NE;
			fcs_pkg::MIN_GT_D: begin
				rel = fcs_pkg::FCS_GT;
				dbl = 1'b1;
			end
			fcs_pkg::MIN_LE_D: begin
				rel = fcs_pkg::FCS_LE;
				dbl = 1'b1;
			end
			fcs_pkg::MIN_LT_D: begin
				rel = fcs_pkg::FCS_LT;
				dbl = 1'b1;
			end
			fcs_pkg::MIN_NE_D: begin
				rel = fcs_pkg::FCS_NE;
				dbl = 1'b1;
			end
			fcs_pkg::MIN_UEQ_D: begin
				rel = fcs_pkg::FCS_UEQ;
				dbl = 1'b1;
			end
			default: legal = 1'b0;
		endcase
	end

	// reserved fields are ignored, only major and minor qualify
	assign insn_hit  = issue & legal & (major == fcs_pkg::MAJOR_FLOAT);
	// compares never target a general-purpose register
	assign gpr_write = 1'b0;

	// insn_hit stays combinational so the issue stage can see the take
	// in the same cycle; everything it feeds below is registered

	////////////////////////////////////////////////////////////////////////
	// operand forming
	// 32-bit core: the pair arrives already read on hi/lo, upper first
	// 64-bit core: one register on lo, the hi lane is never looked at
	logic [63:0] dbl_a; // double view of A
	logic [63:0] dbl_b; // double view of B
	logic [63:0] op_a;  // operand A as compared
	logic [63:0] op_b;  // operand B as compared

	if (CORE_W == 32) begin : g_pair
		// first register of the pair is the upper word
		assign dbl_a = {opa_hi, opa_lo};
		assign dbl_b = {opb_hi, opb_lo};
	end else begin : g_full
		// 64-bit core: lo ports carry whole registers
		assign dbl_a = 64'(opa_lo);
		assign dbl_b = 64'(opb_lo);
	end

	// single precision looks at bits 31..0 only, either core width
	assign op_a = dbl ? dbl_a : {32'h0000_0000, dbl_a[31:0]};
	assign op_b = dbl ? dbl_b : {32'h0000_0000, dbl_b[31:0]};

	////////////////////////////////////////////////////////////////////////
	// classification
	// both operands are classified side by side; the class bits feed
	// the ordering logic and the sticky status events alike
	logic a_inf, a_nan, a_snan, a_zero;
	logic b_inf, b_nan, b_snan, b_zero;

	fcs_class u_cls_a (
		.opnd    (op_a),
		.dbl     (dbl),
		.is_inf  (a_inf),
		.is_nan  (a_nan),
		.is_snan (a_snan),
		.is_zero (a_zero)
	);

	fcs_class u_cls_b (
		.opnd    (op_b),
		.dbl     (dbl),
		.is_inf  (b_inf),
		.is_nan  (b_nan),
		.is_snan (b_snan),
		.is_zero (b_zero)
	);

	////////////////////////////////////////////////////////////////////////
	// ieee ordering
	// a plain integer compare of the patterns would order negatives
	// backwards and split +0 from -0, hence sign-magnitude here
	logic sign_a;   // sign of A
	logic sign_b;   // sign of B
	logic any_nan;  // unordered pair
	logic both_z;   // +0 equals -0
	logic mag_gt;   // |A| > |B|
	logic mag_eq;   // |A| == |B|
	logic f_eq;     // numeric equal
	logic f_gt;     // numeric A > B
	logic result;   // flag value for this op

	assign sign_a  = dbl ? op_a[63] : op_a[31];
	assign sign_b  = dbl ? op_b[63] : op_b[31];
	assign any_nan = a_nan | b_nan;
	assign both_z  = a_zero & b_zero;
	// magnitude compare; upper half zero in single mode
	assign mag_gt  = dbl ? (op_a[62:0] > op_b[62:0])
	                     : (op_a[30:0] > op_b[30:0]);
	assign mag_eq  = dbl ? (op_a[62:0] == op_b[62:0])
	                     : (op_a[30:0] == op_b[30:0]);
	assign f_eq    = both_z | (mag_eq & (sign_a == sign_b));

	// sign-magnitude greater, zero signs collapse
	always_comb begin
		if (both_z)
			f_gt = 1'b0;
		else if (sign_a != sign_b)
			f_gt = sign_b;
		else
			f_gt = sign_a ? (~mag_gt & ~mag_eq) : mag_gt;
	end

	// relation; nan makes ordered relations false
	always_comb begin
		unique case (rel)
			fcs_pkg::FCS_GT: result = ~any_nan & f_gt;
			fcs_pkg::FCS_LE: result = ~any_nan & ~f_gt;
			fcs_pkg::FCS_LT: result = ~any_nan & ~f_gt & ~f_eq;
			// noteq is true for unordered operands as well
			fcs_pkg::FCS_NE: result = any_nan | ~f_eq;
			fcs_pkg::FCS_UEQ: result = any_nan | f_eq;
			default: result = 1'b0;
		endcase
	end
	// single forms share the low-word path above
	// any_nan gate in the ordered relations

	////////////////////////////////////////////////////////////////////////
	// exception events
	// events are qualified by insn_hit only; clk_en gates them where
	// they land, so a frozen cycle neither sets nor loses a bit
	logic ev_inf; // infinity seen
	logic ev_inv; // invalid operation

	assign ev_inf = insn_hit & (a_inf | b_inf);
	// noteq only flags signaling nan; unordered-equal never flags invalid
	always_comb begin
		unique case (rel)
			fcs_pkg::FCS_NE: ev_inv = insn_hit & (a_snan | b_snan);
			fcs_pkg::FCS_UEQ: ev_inv = 1'b0;
			default: ev_inv = insn_hit & any_nan;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// compare flag of the supervision register
	// the flag keeps its value between compares; flag_we_q marks the
	// one cycle in which it carries a fresh result
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_flag_q <= fcs_pkg::FLAG_RST;
			flag_we_q      <= 1'b0;
		end else if (clk_en) begin
			flag_we_q <= insn_hit;
			if (insn_hit)
				compare_flag_q <= result;
		end
	end

	// sticky status bits; a new event wins over a clear
	// a clear from software in the cycle of a new event must not lose
	// that event, so the set term is or-ed in after the clear
	always_ff @(posedge clk) begin
		if (srst) begin
			operand_unbounded_bit_q <= fcs_pkg::STICKY_RST;
			invalid_op_bit_q        <= fcs_pkg::STICKY_RST;
		end else if (clk_en) begin
			operand_unbounded_bit_q <= ev_inf |
				(operand_unbounded_bit_q & ~unbounded_clr);
			invalid_op_bit_q <= ev_inv |
				(invalid_op_bit_q & ~invalid_clr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	// all checks run on the core clock and sleep while srst is high;
	// internal decode terms are used so a check names the exact op
	// rather than re-deriving it from the instruction word
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// one compare in flight: its result lands one edge after the take
	flag_update_a: assert property (clk_en && insn_hit |=>
		flag_we_q && compare_flag_q == $past(result))
		else $error("flag not updated");
	we_pulse_a: assert property (clk_en && !insn_hit |=>
		!flag_we_q)
		else $error("write strobe without compare");
	flag_hold_a: assert property (clk_en && !insn_hit |=>
		$stable(compare_flag_q))
		else $error("flag changed without compare");

	// a low enable must freeze every register, not only the flag
	state_freeze_a: assert property (!clk_en |=>
		$stable(compare_flag_q) && $stable(flag_we_q) &&
		$stable(operand_unbounded_bit_q) && $stable(invalid_op_bit_q))
		else $error("state moved while frozen");

	// unordered operands
	gt_nan_a: assert property (clk_en && insn_hit && any_nan &&
		rel != fcs_pkg::FCS_NE && rel != fcs_pkg::FCS_UEQ |=>
		!compare_flag_q && invalid_op_bit_q)
		else $error("nan ordered compare wrong");
	ne_nan_a: assert property (clk_en && insn_hit && any_nan &&
		rel == fcs_pkg::FCS_NE |=> compare_flag_q)
		else $error("noteq false on nan");
	ne_quiet_a: assert property (clk_en && insn_hit &&
		rel == fcs_pkg::FCS_NE && !a_snan && !b_snan &&
		!invalid_op_bit_q && !invalid_clr |=> !invalid_op_bit_q)
		else $error("quiet nan set invalid");
	ueq_noinv_a: assert property (clk_en && insn_hit &&
		rel == fcs_pkg::FCS_UEQ && !invalid_op_bit_q &&
		!invalid_clr |=> !invalid_op_bit_q)
		else $error("unordered equal set invalid");
	ueq_equal_a: assert property (clk_en && insn_hit &&
		rel == fcs_pkg::FCS_UEQ && op_a == op_b |=> compare_flag_q)
		else $error("unordered equal missed");
	lt_le_a: assert property (clk_en && insn_hit &&
		rel == fcs_pkg::FCS_LT && !any_nan && f_eq |=> !compare_flag_q)
		else $error("less-than true on equal");

	// sticky status bits
	inf_sticky_a: assert property (clk_en && ev_inf |=>
		operand_unbounded_bit_q [*2] ##0 1'b1 or
		(operand_unbounded_bit_q ##1 $past(clk_en && unbounded_clr)))
		else $error("infinity bit lost");
	sticky_hold_a: assert property (clk_en && invalid_op_bit_q &&
		!invalid_clr |=> invalid_op_bit_q)
		else $error("invalid bit dropped");
	inv_wins_a: assert property (clk_en && ev_inv |=>
		invalid_op_bit_q)
		else $error("invalid event lost");
	unb_clear_a: assert property (clk_en && unbounded_clr &&
		!ev_inf |=> !operand_unbounded_bit_q)
		else $error("infinity bit not cleared");
	no_gpr_a: assert property (insn_hit |-> !gpr_write)
		else $error("compare wrote gpr");

	gt_true_c: cover property (clk_en && insn_hit &&
		rel == fcs_pkg::FCS_GT ##1 compare_flag_q);
	dbl_ne_c: cover property (clk_en && insn_hit && dbl &&
		rel == fcs_pkg::FCS_NE);
	inv_set_c: cover property (!invalid_op_bit_q ##1 invalid_op_bit_q);
	inf_set_c: cover property (!operand_unbounded_bit_q ##1
		operand_unbounded_bit_q);
	// event and clear in one cycle, the set must win
	race_c: cover property (clk_en && ev_inf && unbounded_clr);
endmodule
`default_nettype wire

/* bench/fcs_gpr_model.sv */
`timescale 1ns/1ps
`default_nettype none
// decoder and register file that feed the compare unit its operands
module fcs_gpr_model (
	input  wire logic        clk,
	input  wire logic        w_en,
	input  wire logic [4:0]  w_idx,
	input  wire logic [31:0] w_data,
	input  wire logic [31:0] insn,
	output logic      [31:0] opa_hi,
	output logic      [31:0] opa_lo,
	output logic      [31:0] opb_hi,
	output logic      [31:0] opb_lo
);
	logic [31:0] gpr_q [32]; // general-purpose registers
	logic [4:0]  ra;         // first a register
	logic [4:0]  rb;         // first b register
	////////////////////////////////////////////////////////////////////////
	// one write port, loaded by the bench between compares
	always_ff @(posedge clk) begin
		if (w_en) begin
			gpr_q[w_idx] <= w_data;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// operand read; bit 4 of the minor code marks double precision
	always_comb begin
		ra = insn[20:16];
		rb = insn[15:11];
		if (insn[4]) begin
			// named register upper, the next one lower
			opa_hi = gpr_q[ra];
			opa_lo = gpr_q[ra + 5'h01];
			opb_hi = gpr_q[rb];
			opb_lo = gpr_q[rb + 5'h01];
		end else begin
			// unused upper lane carries junk so leaks show
			opa_hi = ~gpr_q[ra];
			opa_lo = gpr_q[ra];
			opb_hi = ~gpr_q[rb];
			opb_lo = gpr_q[rb];
		end
	end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// directed checks of the float set-flag compare unit
module tb_top;
	localparam logic [63:0] S1 = 64'h3F800000;         // single 1.0
	localparam logic [63:0] S2 = 64'h40000000;         // single 2.0
	localparam logic [63:0] QS = 64'h7FC00000;         // single quiet nan
	localparam logic [63:0] IS = 64'h7F800000;         // single infinity
	localparam logic [63:0] D1 = 64'h3FF0000000000000; // double 1.0
	localparam logic [63:0] DP = 64'h3FF0000000000001; // just above 1.0
	localparam logic [63:0] QD = 64'h7FF8000000000000; // double quiet nan
	localparam logic [63:0] SD = 64'h7FF0000000000001; // double signal nan
	localparam logic [63:0] ID = 64'h7FF0000000000000; // double infinity
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        clk_en = 1'b1;
	logic        issue = 1'b0;
	logic [31:0] insn = 32'h0;
	logic        unb_clr = 1'b0;
	logic        inv_clr = 1'b0;
	logic        w_en = 1'b0;
	logic [4:0]  w_idx = 5'h00;
	logic [31:0] w_data = 32'h0;
	logic [31:0] a_hi, a_lo, b_hi, b_lo;
	logic        hit, gpr_wr, fwe, flag, unb, inv;
	logic        fwe64, flag64, unb64, inv64; // outputs of the 64-bit core
	int          miscompares = 0;
	int          num_checks = 0;
	always #2.5 clk = ~clk;
	fcs_gpr_model u_fcs_gpr_model (.clk(clk), .w_en(w_en), .w_idx(w_idx),
		.w_data(w_data), .insn(insn), .opa_hi(a_hi), .opa_lo(a_lo),
		.opb_hi(b_hi), .opb_lo(b_lo));
	fcs_compare #(.CORE_W(32)) u_fcs_compare (.clk(clk), .srst(srst),
		.clk_en(clk_en), .issue(issue), .insn(insn), .opa_hi(a_hi),
		.opa_lo(a_lo), .opb_hi(b_hi), .opb_lo(b_lo), .unbounded_clr(unb_clr),
		.invalid_clr(inv_clr), .insn_hit(hit), .gpr_write(gpr_wr),
		.flag_we_q(fwe), .compare_flag_q(flag),
		.operand_unbounded_bit_q(unb), .invalid_op_bit_q(inv));
	// 64-bit core: whole register on lo, swapped junk on the unused hi lane
	if (1) begin : g_core64
		fcs_compare #(.CORE_W(64)) u_fcs_compare (.clk(clk), .srst(srst),
			.clk_en(clk_en), .issue(issue), .insn(insn),
			.opa_hi({a_lo, a_hi}), .opa_lo({a_hi, a_lo}),
			.opb_hi({b_lo, b_hi}), .opb_lo({b_hi, b_lo}),
			.unbounded_clr(unb_clr), .invalid_clr(inv_clr), .insn_hit(),
			.gpr_write(), .flag_we_q(fwe64), .compare_flag_q(flag64),
			.operand_unbounded_bit_q(unb64), .invalid_op_bit_q(inv64));
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [4:0] i, input logic [31:0] d);
		@(posedge clk);
		#1;
		w_en = 1'b1;
		w_idx = i;
		w_data = d;
	endtask
	// loads both operands, issues one compare, judges its answer
	task cmp(input logic [7:0] mn, input logic [63:0] a, input logic [63:0] b,
		input logic f, input logic u, input logic v);
		wr(5'h02, a[63:32]);
		wr(5'h03, a[31:0]);
		wr(5'h04, b[63:32]);
		wr(5'h05, b[31:0]);
		@(posedge clk);
		#1;
		w_en = 1'b0;
		issue = 1'b1;
		insn = {6'h32, 5'h1F, mn[4] ? 5'h02 : 5'h03, mn[4] ? 5'h04 : 5'h05,
			3'h7, mn};
		#1;
		chk(hit, 1'b1);
		@(posedge clk);
		#1;
		issue = 1'b0;
		chk(fwe, 1'b1);
		chk(flag, f);
		chk(unb, u);
		chk(inv, v);
		chk(gpr_wr, 1'b0);
		chk({fwe64, flag64, unb64, inv64}, {1'b1, f, u, v});
	endtask
	// sticky clear pulse, one cycle
	task clr(input logic u, input logic v);
		@(posedge clk);
		#1;
		unb_clr = u;
		inv_clr = v;
		@(posedge clk);
		#1;
		unb_clr = 1'b0;
		inv_clr = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_single;
		cmp(fcs_pkg::MIN_GT_S, S2, S1, 1'b1, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_LE_S, S1, S1, 1'b1, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_LT_S, S1, S1, 1'b0, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_NE_S, 64'h0, 64'h80000000, 1'b0, 1'b0, 1'b0);
		$display("test single done");
	endtask
	task t_double;
		cmp(fcs_pkg::MIN_GT_D, DP, D1, 1'b1, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_LE_D, DP, D1, 1'b0, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_LT_D, D1, DP, 1'b1, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_NE_D, D1, DP, 1'b1, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_UEQ_D, D1, D1, 1'b1, 1'b0, 1'b0);
		$display("test double done");
	endtask
	// wrong major, unlisted minor, then a frozen clock enable
	task t_refuse;
		@(posedge clk);
		#1;
		issue = 1'b1;
		insn = {6'h33, 18'h0, fcs_pkg::MIN_GT_S};
		#1;
		chk(hit, 1'b0);
		@(posedge clk);
		#1;
		chk(fwe, 1'b0);
		insn = {6'h32, 18'h0, 8'h18};
		#1;
		chk(hit, 1'b0);
		@(posedge clk);
		#1;
		chk(fwe, 1'b0);
		clk_en = 1'b0;
		insn = {6'h32, 18'h0, fcs_pkg::MIN_LT_S};
		@(posedge clk);
		#1;
		chk(fwe, 1'b0);
		chk(flag, 1'b1);
		chk({fwe64, flag64}, 2'h1);
		issue = 1'b0;
		clk_en = 1'b1;
		$display("test refuse done");
	endtask
	task t_nan;
		cmp(fcs_pkg::MIN_NE_S, QS, S1, 1'b1, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_UEQ_D, QD, D1, 1'b1, 1'b0, 1'b0);
		cmp(fcs_pkg::MIN_GT_S, QS, S1, 1'b0, 1'b0, 1'b1);
		clr(1'b0, 1'b1);
		chk(inv, 1'b0);
		cmp(fcs_pkg::MIN_NE_D, SD, D1, 1'b1, 1'b0, 1'b1);
		cmp(fcs_pkg::MIN_LT_D, D1, QD, 1'b0, 1'b0, 1'b1);
		$display("test nan done");
	endtask
	task t_inf;
		cmp(fcs_pkg::MIN_LT_D, ID, D1, 1'b0, 1'b1, 1'b1);
		cmp(fcs_pkg::MIN_LE_S, S1, S2, 1'b1, 1'b1, 1'b1);
		clr(1'b1, 1'b1);
		chk(unb, 1'b0);
		chk(inv, 1'b0);
		cmp(fcs_pkg::MIN_GT_S, IS, S1, 1'b1, 1'b1, 1'b0);
		$display("test inf done");
	endtask
	// infinity event and clear in one cycle, then a reset in mid-run
	task t_race;
		@(posedge clk);
		#1;
		issue = 1'b1;
		unb_clr = 1'b1;
		inv_clr = 1'b1;
		@(posedge clk);
		#1;
		issue = 1'b0;
		unb_clr = 1'b0;
		inv_clr = 1'b0;
		chk({fwe, flag, unb, inv}, 4'hE);
		chk({fwe64, flag64, unb64, inv64}, 4'hE);
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		chk({fwe, flag, unb, inv}, 4'h0);
		chk({fwe64, flag64, unb64, inv64}, 4'h0);
		$display("test race done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog: the tests need well under a microsecond and a half
	initial begin
		#20000;
		miscompares++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge clk);
		#1;
		srst = 1'b0;
		chk({fwe, flag, unb, inv}, 4'h0);
		chk({fwe64, flag64, unb64, inv64}, 4'h0);
		t_single();
		t_double();
		t_refuse();
		t_nan();
		t_inf();
		t_race();
		end_of_test();
	end
endmodule
`default_nettype wire
